/* design/sci_lin_pkg.sv */
package sci_lin_pkg;
	// register byte addresses
	localparam logic [11:0] ADDR_GCR1 = 12'h004;
	localparam logic [11:0] ADDR_GCR2 = 12'h008;
	localparam logic [11:0] ADDR_FLAGS = 12'h00C;
	localparam logic [11:0] ADDR_MASK = 12'h010;
	localparam logic [11:0] ADDR_TXD = 12'h014;
	localparam logic [11:0] ADDR_RXD = 12'h018;
	localparam logic [11:0] ADDR_BAUD = 12'h01C;
	// global_control_one fields
	localparam int B_RELEASE = 7;
	localparam int B_LIN = 6;
	localparam int B_MASTER = 5;
	localparam int B_STOP = 4;
	localparam int B_EVEN = 3;
	localparam int B_PEN = 2;
	localparam int B_TIMING = 1;
	localparam int B_FRAMING = 0;
	// flag_status fields
	localparam int F_BE = 31;
	localparam int F_FE = 26;
	localparam int F_OE = 25;
	localparam int F_PE = 24;
	localparam int F_RX_WAKEUP_MARK = 12;
	localparam int F_TXEMPTY = 11;
	localparam int F_RXFULL = 9;
	localparam int F_TXFREE = 8;
	localparam int F_BUSY = 3;
	localparam int F_IDLE = 2;
	localparam int F_BRK = 0;
	localparam logic [31:0] FLAG_RESET = 32'h00000904;
	localparam logic [31:0] FLAG_W1C = 32'h87001001;
	localparam logic [31:0] GCR2_WMASK = 32'h0003FFFF;
	// reset values and counts
	localparam logic [7:0] GCR1_RESET = 8'h00;
	localparam logic [15:0] BAUD_RESET = 16'h000F;
	localparam logic [3:0] BREAK_BITS = 4'hD;
	localparam logic [3:0] IDLE_BITS = 4'hA;
	localparam logic [3:0] DATA_BITS = 4'h8;
	// state machines
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_BREAK = 2'b01,
		TX_SHIFT = 2'b10
	} tx_st_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_BITS = 3'b010,
		RX_STOP = 3'b011,
		RX_GAP = 3'b100
	} rx_st_t;
endpackage

/* design/sci_lin_frame_config.sv */
`timescale 1ns/10ps
module sci_lin_frame_config
	import sci_lin_pkg::*;
(
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial line
	input wire logic rx_pin,
	output logic tx_pin,
	// status
	output logic irq,
	output logic master_role
);

	typedef struct packed {
		logic [31:0] rdata;
		logic rdy;
		logic err;
		logic irq;
		logic tx;
		logic mst;
		logic [7:0] gcr1;
		logic [17:0] gcr2;
		logic [31:0] flags;
		logic [31:0] mask;
		logic [15:0] baud;
		logic [9:0] txbuf;
		tx_st_t tst;
		logic [12:0] tsh;
		logic [3:0] tlen;
		logic [15:0] tcnt;
		logic [3:0] tbits;
		logic [1:0] rsync;
		rx_st_t rst;
		logic [15:0] rcnt;
		logic [3:0] ridx;
		logic [3:0] pay_n;
		logic [9:0] rsh;
		logic [7:0] rdat;
		logic rab;
		logic [3:0] resp_len;
		logic [1:0] hdr;
		logic [3:0] icnt;
	} state_t;

	state_t q;
	state_t d;

	// outputs straight from the state flops
	assign prdata = q.rdata;
	assign pready = q.rdy;
	assign pslverr = q.err;
	assign irq = q.irq;
	assign tx_pin = q.tx;
	assign master_role = q.mst;

	// next-state logic
	always_comb begin
		logic lin;
		logic frm;
		logic pen;
		logic even;
		logic rx;
		logic acc;
		logic pay;
		logic chk;
		logic idp;
		logic [12:0] fr;
		logic [3:0] n;
		logic [31:0] ev;
		logic [7:0] b;
		lin = q.gcr1[B_LIN];
		frm = q.gcr1[B_FRAMING];
		pen = q.gcr1[B_PEN];
		even = q.gcr1[B_EVEN];
		rx = q.rsync[1];
		acc = psel & penable & q.rdy;
		pay = 1'h0;
		chk = 1'h0;
		idp = 1'h0;
		fr = '1;
		n = 4'h0;
		ev = 32'h00000000;
		b = q.rsh[7:0];
		// every field holds unless a branch below moves it
		d = q;

		// two-flop synchroniser on the receive pin
		d.rsync = {q.rsync[0], rx_pin};

		// apb setup phase: decode, latch read data, raise ready
		d.rdy = psel & ~penable & ~q.rdy;
		// the error answer stands only in the cycle of ready
		d.err = 1'h0;
		if (psel & ~penable & ~q.rdy) begin
			case (paddr)
				ADDR_GCR1: d.rdata = {24'h000000, q.gcr1};
				ADDR_GCR2: d.rdata = {14'h0000, q.gcr2};
				ADDR_FLAGS: d.rdata = q.flags;
				ADDR_MASK: d.rdata = q.mask;
				ADDR_TXD: d.rdata = {22'h000000, q.txbuf};
				ADDR_RXD: d.rdata = {16'h0000, q.resp_len, 3'h0, q.rab, q.rdat};
				ADDR_BAUD: d.rdata = {16'h0000, q.baud};
				default: begin
					d.rdata = 32'h00000000;
					d.err = 1'h1;
				end
			endcase
		end

		// apb access phase: writes and read side effects
		if (acc & pwrite) begin
			case (paddr)
				ADDR_GCR1: d.gcr1 = pwdata[7:0];
				ADDR_GCR2: d.gcr2 = pwdata[17:0];
				ADDR_FLAGS: d.flags = q.flags & ~(pwdata & FLAG_W1C);
				ADDR_MASK: d.mask = pwdata;
				ADDR_BAUD: d.baud = pwdata[15:0];
				ADDR_TXD: begin
					// a full buffer or a held block refuses the byte
					if (q.flags[F_TXFREE] & q.gcr1[B_RELEASE]) begin
						d.txbuf = pwdata[9:0];
						d.flags[F_TXFREE] = 1'h0;
						d.flags[F_TXEMPTY] = 1'h0;
					end
				end
				default: ;
			endcase
		end
		// reading the receive word frees the buffer
		if (acc & ~pwrite & (paddr == ADDR_RXD)) begin
			d.flags[F_RXFULL] = 1'h0;
		end

		// outgoing frame: start, data, address bit, parity, stops
		fr[0] = 1'h0;
		fr[8:1] = q.txbuf[7:0];
		n = 4'h9;
		pay = ^q.txbuf[7:0];
		if (!lin && frm) begin
			fr[n] = q.txbuf[8];
			pay = pay ^ q.txbuf[8];
			n = n + 4'h1;
		end
		if (!lin && pen) begin
			fr[n] = pay ^ ~even;
			n = n + 4'h1;
		end
		// a second stop bit only in SCI mode
		n = n + {3'h0, !lin && q.gcr1[B_STOP]};

		// transmitter
		case (q.tst)
			TX_IDLE: begin
				d.tx = 1'h1;
				// a waiting byte starts on the next edge
				if (!q.flags[F_TXFREE]) begin
					d.flags[F_TXFREE] = 1'h1;
					d.tcnt = q.baud;
					if (lin && q.gcr1[B_MASTER] && q.txbuf[9]) begin
						// master heads the frame with break and delimiter
						d.tst = TX_BREAK;
						d.tx = 1'h0;
						d.tbits = BREAK_BITS - 4'h1;
						d.tsh = {fr[11:0], 1'h1};
						// delimiter first, then every frame bit
						d.tlen = n + 4'h1;
					end else begin
						d.tst = TX_SHIFT;
						d.tx = fr[0];
						d.tsh = fr;
						// last stop bit keeps a full bit time
						d.tlen = n;
					end
				end
			end
			TX_BREAK: begin
				// break bits counted down, then the delimiter
				if (q.tcnt == 16'h0000) begin
					d.tcnt = q.baud;
					if (q.tbits == 4'h0) begin
						d.tst = TX_SHIFT;
						d.tx = q.tsh[0];
					end else begin
						d.tbits = q.tbits - 4'h1;
					end
				end else begin
					d.tcnt = q.tcnt - 16'h0001;
				end
			end
			TX_SHIFT: begin
				// in LIN the line is read back at mid-bit
				if (lin && (q.tcnt == (q.baud >> 1)) && (rx != q.tx)) begin
					ev[F_BE] = 1'h1;
				end
				if (q.tcnt == 16'h0000) begin
					d.tcnt = q.baud;
					if (q.tlen == 4'h0) begin
						d.tst = TX_IDLE;
						d.tx = 1'h1;
						// empty only when no byte waits in the buffer
						d.flags[F_TXEMPTY] = d.flags[F_TXFREE];
					end else begin
						d.tsh = {1'h1, q.tsh[12:1]};
						d.tx = q.tsh[1];
						d.tlen = q.tlen - 4'h1;
					end
				end else begin
					d.tcnt = q.tcnt - 16'h0001;
				end
			end
			default: d.tst = TX_IDLE;
		endcase

		// receiver
		case (q.rst)
			RX_IDLE: begin
				if (!rx) begin
					d.rst = RX_START;
					d.rcnt = q.baud >> 1;
					d.icnt = 4'h0;
					// any start bit ends the idle period
					d.flags[F_IDLE] = 1'h0;
				end else if (q.rcnt == 16'h0000) begin
					// count high bit times towards an idle period
					d.rcnt = q.baud;
					if (q.icnt == IDLE_BITS) begin
						d.flags[F_IDLE] = 1'h1;
					end else begin
						d.icnt = q.icnt + 4'h1;
					end
				end else begin
					d.rcnt = q.rcnt - 16'h0001;
				end
			end
			RX_START: begin
				if (q.rcnt == 16'h0000) begin
					d.rcnt = q.baud;
					d.ridx = 4'h0;
					d.rsh = 10'h000;
					d.pay_n = DATA_BITS + {3'h0, !lin && frm}
						+ {3'h0, !lin && pen};
					// a start bit gone high at mid-bit was a glitch
					d.rst = rx ? RX_IDLE : RX_BITS;
				end else begin
					d.rcnt = q.rcnt - 16'h0001;
				end
			end
			RX_BITS: begin
				if (q.rcnt == 16'h0000) begin
					d.rcnt = q.baud;
					// payload sampled at mid-bit, lsb first
					d.rsh[q.ridx] = rx;
					if (q.ridx == q.pay_n - 4'h1) begin
						d.rst = RX_STOP;
					end else begin
						d.ridx = q.ridx + 4'h1;
					end
				end else begin
					d.rcnt = q.rcnt - 16'h0001;
				end
			end
			RX_STOP: begin
				if (q.rcnt == 16'h0000) begin
					// only the first stop bit is checked
					d.rcnt = q.baud;
					d.rst = RX_IDLE;
					if (!lin && !frm && q.gcr1[B_STOP]) begin
						d.rst = RX_GAP;
					end
					if (!rx) begin
						ev[F_FE] = 1'h1;
						// a low stop over an all-zero payload is a break
						if (q.rsh == 10'h000) begin
							ev[F_BRK] = 1'h1;
							d.hdr = 2'h2;
						end
					end else begin
						// a byte arriving before the last was read overruns
						ev[F_OE] = q.flags[F_RXFULL];
						ev[F_RXFULL] = 1'h1;
						d.rdat = b;
						d.rab = !lin && frm && q.rsh[8];
						ev[F_RX_WAKEUP_MARK] = !lin && frm && q.rsh[8];
						// data, address bit and parity together
						chk = ^b ^ (frm & q.rsh[8])
							^ q.rsh[frm ? 9 : 8];
						if (!lin && pen && (chk == even)) begin
							ev[F_PE] = 1'h1;
						end
						// header phase: break, then sync, then identifier
						if (lin && (q.hdr != 2'h0)) begin
							d.hdr = q.hdr - 2'h1;
						end
						if (lin && (q.hdr == 2'h1)) begin
							// identifier byte: protection bits
							idp = (b[6] != (b[0] ^ b[1] ^ b[2] ^ b[4]))
								|| (b[7] != ~(b[1] ^ b[3] ^ b[4] ^ b[5]));
							ev[F_PE] = pen && idp;
							d.resp_len = 4'h0;
							if (frm) begin
								case (b[5:4])
									2'h2: d.resp_len = 4'h4;
									2'h3: d.resp_len = 4'h8;
									default: d.resp_len = 4'h2;
								endcase
							end
						end
					end
				end else begin
					d.rcnt = q.rcnt - 16'h0001;
				end
			end
			RX_GAP: begin
				// without address framing, idle counting waits out the second stop bit
				if (q.rcnt == 16'h0000) begin
					d.rcnt = q.baud;
					d.rst = RX_IDLE;
				end else begin
					d.rcnt = q.rcnt - 16'h0001;
				end
			end
			default: d.rst = RX_IDLE;
		endcase

		// events win over a clear in the same cycle
		d.flags = d.flags | ev;
		// busy follows the receiver, not a stored bit
		d.flags[F_BUSY] = (d.rst != RX_IDLE);

		// soft hold: engines idle, flags frozen at reset values
		if (!q.gcr1[B_RELEASE]) begin
			d.flags = FLAG_RESET;
			d.tst = TX_IDLE;
			d.rst = RX_IDLE;
			d.tx = 1'h1;
			d.hdr = 2'h0;
			d.icnt = 4'h0;
			d.rcnt = q.baud;
		end

		// role output and interrupt level
		d.mst = lin && q.gcr1[B_MASTER];
		d.irq = |(q.flags & q.mask);
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// fields not named below clear to zero
			q <= '0;
			q.gcr1 <= GCR1_RESET;
			q.flags <= FLAG_RESET;
			q.baud <= BAUD_RESET;
			q.tx <= 1'h1;
			q.rsync <= 2'h3;
			q.tst <= TX_IDLE;
			q.rst <= RX_IDLE;
		end else begin
			q <= d;
		end
	end

endmodule

/* bench/sci_lin_frame_config_assertions.sv */
`timescale 1ns/10ps
module frame_cfg_checker
	import sci_lin_pkg::*;
(
	// apb side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// line and status
	input wire logic rx_pin,
	input wire logic tx_pin,
	input wire logic irq,
	input wire logic master_role
);
	logic rel_q;
	logic role_q;
	logic wr;
	assign wr = psel && penable && pready && pwrite && paddr == ADDR_GCR1;
	// shadow of release and role as software wrote them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rel_q <= 1'b0;
			role_q <= 1'b0;
		end else if (wr) begin
			rel_q <= pwdata[B_RELEASE];
			role_q <= pwdata[B_LIN] & pwdata[B_MASTER];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_cause: assert property (pready |-> $past(psel && !penable))
		else $error("ready without setup");
	a_ready_one: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error answer");
	a_gcr2_zero: assert property (pready && !pwrite && paddr == ADDR_GCR2
		|-> prdata[31:18] == 14'h0) else $error("reserved bits set");
	a_flag_frozen: assert property (pready && !pwrite &&
		paddr == ADDR_FLAGS && !rel_q |-> prdata == FLAG_RESET)
		else $error("flags moved in hold");
	a_hold_idle: assert property (!rel_q |=> tx_pin)
		else $error("line active in hold");
	a_role_set: assert property ($stable(role_q) [*3]
		|-> master_role == role_q) else $error("role mismatch");
endmodule
bind sci_lin_frame_config frame_cfg_checker chk (.pclk, .presetn, .paddr,
	.psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .rx_pin,
	.tx_pin, .irq, .master_role);

/* bench/line_peer.sv */
`timescale 1ns/10ps
module line_peer #(
	parameter int BIT = 4
) (
	// bench side
	input wire logic pclk,
	input wire logic go,
	input wire logic [15:0] frame,
	input wire logic [4:0] nbits,
	// line, idles high
	output logic rx_line
);
	int i;
	// shift the frame out lsb first on request
	initial begin
		rx_line = 1'b1;
		forever begin
			@(posedge pclk);
			if (go) begin
				for (i = 0; i < nbits; i++) begin
					rx_line <= frame[i];
					repeat (BIT) @(posedge pclk);
				end
				rx_line <= 1'b1;
			end
		end
	end
endmodule

/* bench/sci_lin_frame_config_test.sv */
`timescale 1ns/10ps
module sci_lin_frame_config_test
	import sci_lin_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, rx_pin, tx_pin, go;
	logic pready, pslverr, irq, master_role, serr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed, r;
	logic [15:0] frame, got, ef;
	logic [8:0] d;
	logic [4:0] nbits, nb;
	int err_count, total_checks;
	sci_lin_frame_config dut (.pclk, .presetn, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .rx_pin, .tx_pin,
		.irq, .master_role);
	line_peer #(.BIT(4)) peer (.pclk, .go, .frame, .nbits, .rx_line(rx_pin));
	// 25 MHz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// c: [3] two stops [2] even [1] parity on [0] address framing
	function automatic logic [15:0] expf(input logic [8:0] v,
		input logic [3:0] c, output logic [4:0] n);
		logic [15:0] f;
		logic x;
		f = {7'h00, v[7:0], 1'b0};
		n = 5'h09;
		x = ^v[7:0] ^ (c[0] & v[8]);
		if (c[0]) begin
			f[n] = v[8];
			n++;
		end
		if (c[1]) begin
			f[n] = c[2] ? x : ~x;
			n++;
		end
		f[n] = 1'b1;
		f[n + 1] = c[3];
		n += 2;
		return f;
	endfunction
	// identifier with its protection bits; bad flips the low one
	function automatic logic [7:0] idb(input logic [5:0] i,
		input logic bad);
		logic p0;
		logic p1;
		p0 = i[0] ^ i[1] ^ i[2] ^ i[4] ^ bad;
		p1 = ~(i[1] ^ i[3] ^ i[4] ^ i[5]);
		return {p1, p0, i};
	endfunction
	// response length chosen by the two top identifier bits
	function automatic logic [3:0] lenof(input logic [5:0] i);
		case (i[5:4])
			2'h2: return 4'h4;
			2'h3: return 4'h8;
			default: return 4'h2;
		endcase
	endfunction
	// one frame from the line peer, then time to receive it
	task automatic send(input logic [15:0] f, input logic [4:0] n);
		frame <= f;
		nbits <= n;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (60) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] v);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20) begin
			err_count++;
			$display("Error %0t: no ready", $time);
		end
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic grab(input logic [4:0] n);
		int k;
		k = 0;
		got = 16'h0000;
		while (tx_pin !== 1'b0 && k < 500) begin
			@(posedge pclk);
			k++;
		end
		repeat (2) @(posedge pclk);
		for (int i = 0; i < n; i++) begin
			got[i] = tx_pin;
			repeat (4) @(posedge pclk);
		end
	endtask
	task automatic irq_is(input logic e);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		tally_and_finish;
	end
	// main sequence
	initial begin
		seed = 32'h31E4A81D;
		{presetn, psel, penable, pwrite, go} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		frame = 16'hFFFF;
		nbits = 5'h00;
		err_count = 0;
		total_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b1, ADDR_FLAGS, 32'hFFFFFFFF);
		apb(1'b0, ADDR_FLAGS, 32'h0);
		chk(rd, FLAG_RESET);
		apb(1'b1, ADDR_GCR2, 32'hFFFFFFFF);
		apb(1'b0, ADDR_GCR2, 32'h0);
		chk(rd, GCR2_WMASK);
		apb(1'b0, 12'hFF0, 32'h0);
		chk({31'h0, serr}, 32'h1);
		apb(1'b1, ADDR_BAUD, 32'h3);
		// every framing option, two bytes back to back
		for (int c = 0; c < 16; c++) begin
			r = rnd();
			d = r[8:0];
			apb(1'b1, ADDR_GCR1, {27'h0, c[3:1], 1'b1, c[0]});
			apb(1'b1, ADDR_GCR1, {24'h0, 3'h4, c[3:1], 1'b1, c[0]});
			ef = expf(d, c[3:0], nb);
			fork
				grab(nb);
				begin
					apb(1'b1, ADDR_TXD, {23'h0, d});
					apb(1'b1, ADDR_TXD, {23'h0, ~d});
				end
			join
			chk({16'h0, got}, {16'h0, ef});
			repeat (60) @(posedge pclk);
		end
		// receive good then corrupted parity, odd mode
		apb(1'b1, ADDR_GCR1, 32'h06);
		apb(1'b1, ADDR_GCR1, 32'h86);
		apb(1'b1, ADDR_MASK, 32'h01000000);
		r = rnd();
		for (int j = 0; j < 2; j++) begin
			send({6'h3F, ~^r[7:0] ^ j[0], r[7:0], 1'b0}, 5'h0B);
			apb(1'b0, ADDR_RXD, 32'h0);
			chk({24'h0, rd[7:0]}, {24'h0, r[7:0]});
			apb(1'b0, ADDR_FLAGS, 32'h0);
			chk({31'h0, rd[F_PE]}, {31'h0, j[0]});
		end
		irq_is(1'b1);
		apb(1'b1, ADDR_MASK, 32'h0);
		irq_is(1'b0);
		apb(1'b1, ADDR_MASK, 32'h01000000);
		irq_is(1'b1);
		apb(1'b1, ADDR_FLAGS, 32'h01000000);
		irq_is(1'b0);
		// LIN slave: break, sync, then an identifier, good then bad
		apb(1'b1, ADDR_GCR1, 32'h45);
		apb(1'b1, ADDR_GCR1, 32'hC5);
		for (int j = 0; j < 2; j++) begin
			r = rnd();
			apb(1'b1, ADDR_FLAGS, 32'hFFFFFFFF);
			send(16'h0000, 5'h0A);
			send({6'h3F, 1'b1, 8'h55, 1'b0}, 5'h0A);
			send({6'h3F, 1'b1, idb(r[5:0], j[0]), 1'b0}, 5'h0A);
			apb(1'b0, ADDR_RXD, 32'h0);
			chk({28'h0, rd[15:12]}, {28'h0, lenof(r[5:0])});
			chk({24'h0, rd[7:0]}, {24'h0, idb(r[5:0], j[0])});
			apb(1'b0, ADDR_FLAGS, 32'h0);
			chk({31'h0, rd[F_PE]}, {31'h0, j[0]});
			chk({31'h0, rd[F_BRK]}, 32'h1);
		end
		// node role in both protocols
		apb(1'b1, ADDR_GCR1, 32'h60);
		apb(1'b1, ADDR_GCR1, 32'hE0);
		irq_is(1'b0);
		chk({31'h0, master_role}, 32'h1);
		apb(1'b1, ADDR_GCR1, 32'h20);
		irq_is(1'b0);
		chk({31'h0, master_role}, 32'h0);
		tally_and_finish;
	end
endmodule
